// File: include/ctl_io_pkg.sv
package ctl_io_pkg;

  // ************************************************************
  // Channel counts
  // ************************************************************
  localparam int N_IN  = 3;               // DSR, DCD, CTS
  localparam int N_OUT = 2;               // DTR, RTS
  localparam int IDX_DSR = 0;             // Input index of data-set-ready
  localparam int IDX_DCD = 1;             // Input index of carrier detect
  localparam int IDX_CTS = 2;             // Input index of clear-to-send
  localparam int IDX_DTR = 0;             // Output index of terminal-ready
  localparam int IDX_RTS = 1;             // Output index of request-to-send

  // ************************************************************
  // Setting encodings
  // ************************************************************
  typedef enum logic [1:0] {
    LATCH_NONE    = 2'h0,
    LATCH_RISE    = 2'h1,                 // Inactive-to-active
    LATCH_FALL    = 2'h2                  // Active-to-inactive
  } latch_mode_t;

  typedef enum logic [1:0] {
    TRIG_DISABLED = 2'h0,
    TRIG_INACTIVE = 2'h1,
    TRIG_ACTIVE   = 2'h2
  } trig_mode_t;

  typedef enum logic [1:0] {
    FS_NONE       = 2'h0,
    FS_ACTIVATE   = 2'h1,
    FS_DEACTIVATE = 2'h2
  } fs_action_t;

  // ************************************************************
  // Reset values and timer
  // ************************************************************
  localparam logic       INVERT_RST      = 1'b0;
  localparam logic       MANUAL_RST      = 1'b0;  // Auto clear after reset
  localparam logic       NOTIFY_EN_RST   = 1'b0;
  localparam logic       CH_EN_RST       = 1'b0;
  localparam logic       OUT_RST         = 1'b0;
  localparam int         FS_CNT_W        = 32;    // Failsafe interval counter width
  localparam logic [31:0] FS_INTERVAL_RST = 32'h0000_0000; // Reset value of the idle counter, not the interval

endpackage : ctl_io_pkg

// File: core/in_channel.sv
`timescale 1ns/10ps
`default_nettype none

// One input channel: sampling, latch, inversion, alarm
module in_channel
  import ctl_io_pkg::*;
(
  // Clock and reset
  input  wire logic           i_core_clk,
  input  wire logic           i_rstn,
  // Line and control
  input  wire logic           i_line,
  input  wire logic           i_mode_en,
  input  wire logic           i_en,
  input  wire logic           i_invert,
  input  wire latch_mode_t    i_latch_mode,
  input  wire logic           i_latch_clr,
  input  wire trig_mode_t     i_trig,
  input  wire logic           i_manual,
  input  wire logic           i_alarm_clr,
  // Results
  output logic                o_status,
  output logic                o_latched,
  output logic                o_alarm,
  output logic                o_set_pulse,
  output logic                o_clr_pulse,
  output logic                o_activity
);

  // ************************************************************
  // Sampling
  // ************************************************************
  logic sample_r;                          // Last sampled line level
  logic prev_r;                            // Previous sample for edges
  logic live;                              // Sampling allowed
  logic rise;                              // Inactive-to-active edge
  logic fall;                              // Active-to-inactive edge
  logic alarm_nxt;                         // Next alarm state
  logic raise;                             // Trigger condition met
  logic drop;                              // Auto clear condition met

  assign live = i_mode_en & i_en;
  assign rise = live & sample_r & ~prev_r;
  assign fall = live & ~sample_r & prev_r;

  // Sample only while enabled; a disabled line freezes
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sample_r <= 1'b0;
      prev_r   <= 1'b0;
    end else if (live) begin
      sample_r <= i_line;
      prev_r   <= sample_r;
    end else begin
      prev_r   <= sample_r;                 // No false edge on re-enable
    end
  end

  // Reported status honours inversion
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status <= 1'b0;
    end else begin
      o_status <= sample_r ^ i_invert;
    end
  end

  // ************************************************************
  // Transition latch
  // ************************************************************
  // Capture beats clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_latched <= 1'b0;
    end else if ((i_latch_mode == LATCH_RISE && rise) ||
                 (i_latch_mode == LATCH_FALL && fall)) begin
      o_latched <= 1'b1;
    end else if (i_latch_clr || i_latch_mode == LATCH_NONE) begin
      o_latched <= 1'b0;
    end
  end

  // ************************************************************
  // Alarm
  // ************************************************************
  // Edges are on the raw line; inversion affects only the status
  assign raise = (i_trig == TRIG_INACTIVE && fall) ||
                 (i_trig == TRIG_ACTIVE && rise);
  assign drop  = (i_trig == TRIG_INACTIVE && rise) ||
                 (i_trig == TRIG_ACTIVE && fall);

  always_comb begin
    alarm_nxt = o_alarm;
    if (i_trig == TRIG_DISABLED) begin
      alarm_nxt = 1'b0;
    end else if (raise) begin
      alarm_nxt = 1'b1;                     // Set wins over clear
    end else if (!i_manual && drop) begin
      alarm_nxt = 1'b0;
    end else if (i_manual && i_alarm_clr) begin
      alarm_nxt = 1'b0;
    end
  end

  // Alarm state and its set and clear events
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_alarm     <= 1'b0;
      o_set_pulse <= 1'b0;
      o_clr_pulse <= 1'b0;
      o_activity  <= 1'b0;
    end else begin
      o_alarm     <= alarm_nxt;
      o_set_pulse <= alarm_nxt & ~o_alarm;
      o_clr_pulse <= ~alarm_nxt & o_alarm;
      o_activity  <= rise | fall;
    end
  end

endmodule : in_channel

`default_nettype wire

// File: core/ctl_line_io.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Modem status lines in, control lines out
// - Each channel has its own enable
// - Inputs latch selected transition; default none
// - Inversion complements reported status; default off
// - Trigger disabled never raises alarms
// - Inactive trigger: active-to-inactive raises alarm
// - Active trigger: inactive-to-active raises alarm
// - Auto clear drops alarm on return
// - Manual clear holds alarm until cleared
// - Alarm set/clear notify per enabled path
// - Failsafe fires after idle interval elapses
// - Failsafe action: none, activate, deactivate
module ctl_line_io
  import ctl_io_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rstn,
  // Mode and channel enables
  input  wire logic                      i_io_mode,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  i_in_en,
  input  wire logic [ctl_io_pkg::N_OUT-1:0] i_out_en,
  // Input lines
  input  wire logic                      i_dsr,
  input  wire logic                      i_dcd,
  input  wire logic                      i_cts,
  // Input configuration, two bits per channel for modes
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_invert,
  input  wire logic [2*ctl_io_pkg::N_IN-1:0] i_latch_mode,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_latch_clr,
  input  wire logic [2*ctl_io_pkg::N_IN-1:0] i_trig,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_sel_auto,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_sel_manual,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_alarm_clr,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_email_en,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_syslog_en,
  input  wire logic [ctl_io_pkg::N_IN-1:0]   i_snmp_en,
  // Output control
  input  wire logic [ctl_io_pkg::N_OUT-1:0]   i_out_wr,
  input  wire logic [ctl_io_pkg::N_OUT-1:0]   i_out_val,
  input  wire logic [2*ctl_io_pkg::N_OUT-1:0] i_fs_action,
  input  wire logic [31:0]                    i_fs_interval,
  // Output lines
  output logic                           o_dtr,
  output logic                           o_dtr_oe,
  output logic                           o_rts,
  output logic                           o_rts_oe,
  // Status
  output logic [ctl_io_pkg::N_IN-1:0]    o_status,
  output logic [ctl_io_pkg::N_IN-1:0]    o_latched,
  output logic [ctl_io_pkg::N_IN-1:0]    o_alarm,
  output logic [ctl_io_pkg::N_IN-1:0]    o_manual,
  output logic                           o_fs_expired,
  // Notification events, one-cycle pulses
  output logic [ctl_io_pkg::N_IN-1:0]    o_email_evt,
  output logic [ctl_io_pkg::N_IN-1:0]    o_syslog_evt,
  output logic [ctl_io_pkg::N_IN-1:0]    o_snmp_evt,
  output logic [ctl_io_pkg::N_IN-1:0]    o_evt_raised
);

  // ************************************************************
  // Declarations
  // ************************************************************
  // Gathered lines and clear mode
  logic [N_IN-1:0]     line;               // Gathered input lines
  logic [N_IN-1:0]     manual_r;           // Manual clear selected
  // Per-channel results, one bit per input
  logic [N_IN-1:0]     st_w;               // Channel status
  logic [N_IN-1:0]     lat_w;              // Channel latch
  logic [N_IN-1:0]     alm_w;              // Channel alarm
  logic [N_IN-1:0]     set_w;              // Alarm raised pulse
  logic [N_IN-1:0]     clr_w;              // Alarm cleared pulse
  logic [N_IN-1:0]     act_w;              // Input transition seen
  // Output and failsafe state
  logic [N_OUT-1:0]    out_r;              // Output drive state
  logic [N_OUT-1:0]    oe;                 // Output enable per channel
  logic [FS_CNT_W-1:0] fs_cnt_r;           // Idle cycle counter
  logic                activity;           // Any I/O activity this cycle
  logic                fs_fire;            // Timer expiry pulse

  // Bit order follows the package input indices
  assign line = {i_cts, i_dcd, i_dsr};

  // ************************************************************
  // Clear mode selection
  // ************************************************************
  // One register holds the choice, so both can never be set
  // Auto beats manual in one cycle, so a confused host
  // falls back to the safer self-clearing mode
  // Each input keeps its own bit, independent of the others
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      manual_r <= {N_IN{MANUAL_RST}};
    end else begin
      manual_r <= (manual_r | i_sel_manual) & ~i_sel_auto;
    end
  end

  // ************************************************************
  // Input channels
  // ************************************************************
  // One instance per status line, indexed DSR, DCD, CTS
  // Port mode gates every channel on top of its own enable
  // Mode fields are cast back to their enums at the pins
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      in_channel u_in (
        .i_core_clk   (i_core_clk),
        .i_rstn       (i_rstn),
        .i_line       (line[g]),
        .i_mode_en    (i_io_mode),
        .i_en         (i_in_en[g]),
        .i_invert     (i_invert[g]),
        .i_latch_mode (latch_mode_t'(i_latch_mode[2*g +: 2])),
        .i_latch_clr  (i_latch_clr[g]),
        .i_trig       (trig_mode_t'(i_trig[2*g +: 2])),
        .i_manual     (manual_r[g]),
        .i_alarm_clr  (i_alarm_clr[g]),
        .o_status     (st_w[g]),
        .o_latched    (lat_w[g]),
        .o_alarm      (alm_w[g]),
        .o_set_pulse  (set_w[g]),
        .o_clr_pulse  (clr_w[g]),
        .o_activity   (act_w[g])
      );
    end
  endgenerate

  // Status registered once more so all outputs leave flops
  // Costs one cycle against the channel outputs
  // Manual mode is shown so the host knows which clear applies
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status  <= '0;
      o_latched <= '0;
      o_alarm   <= '0;
      o_manual  <= '0;
    end else begin
      o_status  <= st_w;
      o_latched <= lat_w;
      o_alarm   <= alm_w;
      o_manual  <= manual_r;
    end
  end

  // ************************************************************
  // Notification events
  // ************************************************************
  // Each path only sees events while its own enable is set
  // A cleared alarm notifies as well as a raised one
  // Gating after the event: a late enable replays nothing
  // The raised-only pulse lets a host tell the two apart
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_email_evt  <= '0;
      o_syslog_evt <= '0;
      o_snmp_evt   <= '0;
      o_evt_raised <= '0;
    end else begin
      o_email_evt  <= (set_w | clr_w) & i_email_en;
      o_syslog_evt <= (set_w | clr_w) & i_syslog_en;
      o_snmp_evt   <= (set_w | clr_w) & i_snmp_en;
      o_evt_raised <= set_w;
    end
  end

  // ************************************************************
  // Failsafe timer
  // ************************************************************
  // Activity is an edge on a live input or an accepted write
  // A write to a disabled output is not activity
  // Fire sits one count early so expiry lands on the interval
  assign oe       = i_out_en & {N_OUT{i_io_mode}};
  assign activity = (|act_w) | (|(i_out_wr & oe));
  assign fs_fire  = (i_fs_interval != 32'h0000_0000) &&
                    (fs_cnt_r == i_fs_interval - 32'h0000_0001);

  // Counts idle cycles; a zero interval disables the timer
  // Parks at the interval after firing, so the action is
  // applied once until activity restarts the count
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fs_cnt_r <= FS_INTERVAL_RST;
    end else if (activity || i_fs_interval == 32'h0000_0000) begin
      fs_cnt_r <= '0;
    end else if (fs_cnt_r < i_fs_interval) begin
      fs_cnt_r <= fs_cnt_r + 32'h0000_0001;
    end
  end

  // Expiry flag stays until activity restarts the interval
  // Set beats activity in the same cycle, as for any flag
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fs_expired <= 1'b0;
    end else begin
      if (fs_fire) begin
        o_fs_expired <= 1'b1;
      end else if (activity) begin
        o_fs_expired <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Output channels
  // ************************************************************
  // Write wins over failsafe; failsafe acts once per expiry
  // A disabled output keeps its stored level, undriven
  // Action none leaves the stored level as it is
  // Each output has its own enable and action field
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_r <= {N_OUT{OUT_RST}};
    end else begin
      for (int k = 0; k < N_OUT; k++) begin
        if (i_out_wr[k] && oe[k]) begin
          out_r[k] <= i_out_val[k];
        end else if (fs_fire && oe[k]) begin
          case (fs_action_t'(i_fs_action[2*k +: 2]))
            FS_ACTIVATE:   out_r[k] <= 1'b1;
            FS_DEACTIVATE: out_r[k] <= 1'b0;
            default:       out_r[k] <= out_r[k];
          endcase
        end
      end
    end
  end

  // Pins driven only by enabled channels in I/O mode
  // Level forced low with the enable off, so a released
  // pin never shows stale data on the local side
  // Enables follow the gate a cycle late, in step with the level
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dtr    <= 1'b0;
      o_dtr_oe <= 1'b0;
      o_rts    <= 1'b0;
      o_rts_oe <= 1'b0;
    end else begin
      o_dtr    <= out_r[IDX_DTR] & oe[IDX_DTR];
      o_dtr_oe <= oe[IDX_DTR];
      o_rts    <= out_r[IDX_RTS] & oe[IDX_RTS];
      o_rts_oe <= oe[IDX_RTS];
    end
  end

endmodule : ctl_line_io

`default_nettype wire

// File: testbench/ctl_line_io_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Port checker, channel 0 and DTR
// ************************************************************
module ctl_line_io_checker
  import ctl_io_pkg::*;
(
  // Clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rstn,
  // Stimulus side
  input  wire logic                         i_io_mode,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  i_in_en,
  input  wire logic [ctl_io_pkg::N_OUT-1:0] i_out_en,
  input  wire logic                         i_dsr,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  i_invert,
  input  wire logic [5:0]                   i_latch_mode,
  input  wire logic [5:0]                   i_trig,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  i_sel_auto,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  i_alarm_clr,
  input  wire logic [ctl_io_pkg::N_OUT-1:0] i_out_wr,
  input  wire logic [3:0]                   i_fs_action,
  // Design side
  input  wire logic                         o_dtr,
  input  wire logic                         o_dtr_oe,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  o_status,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  o_latched,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  o_alarm,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  o_manual,
  input  wire logic                         o_fs_expired,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  o_email_evt,
  input  wire logic [ctl_io_pkg::N_IN-1:0]  o_evt_raised
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Expiry with an action pending and no write racing it
  sequence s_fs_fire;
    $rose(o_fs_expired) && !$past(i_out_wr[0]) && o_dtr_oe && $past(i_fs_action[1:0]) != 2'h0;
  endsequence
  // Manual alarm with nothing pending that may drop it
  sequence s_held;
    o_manual[0] && o_alarm[0] && !i_alarm_clr[0] && !$past(i_alarm_clr[0]) &&
      !i_sel_auto[0] && i_trig[1:0] != 2'h0 && $stable(i_trig[1:0]);
  endsequence
  a_evt_align: assert property (o_email_evt[0] |-> o_alarm[0] != $past(o_alarm[0]))
    else $error("event without alarm change");
  a_raise_evt: assert property (o_evt_raised[0] |-> $rose(o_alarm[0]))
    else $error("raise pulse without raise");
  a_trig_off: assert property ((i_trig[1:0] == 2'h0) [*3] |-> !o_alarm[0])
    else $error("alarm with trigger disabled");
  a_manual_hold: assert property (s_held |=> o_alarm[0])
    else $error("manual alarm dropped alone");
  a_manual_clr: assert property (o_manual[0] && o_alarm[0] && i_alarm_clr[0] &&
    $past(i_dsr) == $past(i_dsr, 2) && !$past(i_sel_auto[0]) |-> ##[1:2] !o_alarm[0])
    else $error("manual clear ignored");
  a_auto_wins: assert property (i_sel_auto[0] |-> ##[1:2] !o_manual[0])
    else $error("auto select did not leave manual");
  a_out_gate: assert property ((!i_io_mode || !i_out_en[0]) [*2] |-> !o_dtr_oe && !o_dtr)
    else $error("disabled output driven");
  a_fs_action: assert property (s_fs_fire |=>
    o_dtr == ($past(i_fs_action[1:0], 2) == 2'h1))
    else $error("failsafe action not applied");
  a_status_inv: assert property ((i_io_mode && i_in_en[0] && $stable(i_dsr) &&
    $stable(i_invert[0])) [*4] |-> o_status[0] == (i_dsr ^ i_invert[0]))
    else $error("status not line xor invert");
  a_latch_none: assert property ((i_latch_mode[1:0] == 2'h0) [*3] |-> !o_latched[0])
    else $error("latched with mode none");
endmodule : ctl_line_io_checker

bind ctl_line_io ctl_line_io_checker i_ctl_line_io_checker (.i_core_clk, .i_rstn, .i_io_mode,
  .i_in_en, .i_out_en, .i_dsr, .i_invert, .i_latch_mode, .i_trig, .i_sel_auto, .i_alarm_clr,
  .i_out_wr, .i_fs_action, .o_dtr, .o_dtr_oe, .o_status, .o_latched, .o_alarm, .o_manual,
  .o_fs_expired, .o_email_evt, .o_evt_raised);
`default_nettype wire

// File: testbench/serial_equip_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Far-side serial equipment
// ************************************************************
module serial_equip_model (
  // Clock
  input  wire logic       i_core_clk,
  // Wanted levels of DSR, DCD, CTS
  input  wire logic [2:0] i_want,
  // Pins from the block
  input  wire logic       i_dtr,
  input  wire logic       i_dtr_oe,
  input  wire logic       i_rts,
  input  wire logic       i_rts_oe,
  // Driven status lines and seen output pins
  output logic      [2:0] o_lines,
  output logic      [1:0] o_seen
);
  logic [1:0] last_r;  // Last driven pin levels
  // Status lines move on the clock edge only
  always_ff @(posedge i_core_clk) begin
    o_lines <= i_want;
  end
  // No pull on the pins, so a released pin reads inverted
  always_ff @(posedge i_core_clk) begin
    if (i_dtr_oe) last_r[0] <= i_dtr;
    if (i_rts_oe) last_r[1] <= i_rts;
  end
  assign o_seen = {i_rts_oe ? i_rts : ~last_r[1], i_dtr_oe ? i_dtr : ~last_r[0]};
endmodule : serial_equip_model
`default_nettype wire

// File: testbench/tb_ctl_line_io.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Bench for the control-line I/O block
// ************************************************************
module tb_ctl_line_io;
  import ctl_io_pkg::*;
  logic        clk, rstn, io_mode, dsr, dcd, cts, dtr, dtr_oe, rts, rts_oe, fs_exp;
  logic [2:0]  in_en, inv, lclr, sauto, sman, aclr, em_en, sl_en, sn_en, want;
  logic [2:0]  st, la, al, man, e_em, e_sl, e_sn, e_r;
  logic [5:0]  lmode, trig;
  logic [1:0]  out_en, out_wr, out_val, seen;
  logic [3:0]  fs_act;
  logic [31:0] fs_int, lfsr;
  int          err_count, num_checks, n;
  int          n_em[3], n_sl[3], n_sn[3], x_em[3], x_sl[3], x_sn[3];
  int          m_ln[3], m_al[3], m_la[3], m_mn[3];  // Reference model state
  ctl_line_io i_ctl_line_io (.i_core_clk(clk), .i_rstn(rstn), .i_io_mode(io_mode),
    .i_in_en(in_en), .i_out_en(out_en), .i_dsr(dsr), .i_dcd(dcd), .i_cts(cts),
    .i_invert(inv), .i_latch_mode(lmode), .i_latch_clr(lclr), .i_trig(trig),
    .i_sel_auto(sauto), .i_sel_manual(sman), .i_alarm_clr(aclr), .i_email_en(em_en),
    .i_syslog_en(sl_en), .i_snmp_en(sn_en), .i_out_wr(out_wr), .i_out_val(out_val),
    .i_fs_action(fs_act), .i_fs_interval(fs_int), .o_dtr(dtr), .o_dtr_oe(dtr_oe),
    .o_rts(rts), .o_rts_oe(rts_oe), .o_status(st), .o_latched(la), .o_alarm(al),
    .o_manual(man), .o_fs_expired(fs_exp), .o_email_evt(e_em), .o_syslog_evt(e_sl),
    .o_snmp_evt(e_sn), .o_evt_raised(e_r));
  serial_equip_model i_serial_equip_model (.i_core_clk(clk), .i_want(want), .i_dtr(dtr),
    .i_dtr_oe(dtr_oe), .i_rts(rts), .i_rts_oe(rts_oe), .o_lines({cts, dcd, dsr}),
    .o_seen(seen));
  // ************************************************************
  // Clock, event counting, helpers
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tally notification pulses per path and channel
  always @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      n_em[k] += e_em[k];
      n_sl[k] += e_sl[k];
      n_sn[k] += e_sn[k];
    end
  end
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Alarm moved in the model: expect one event on each enabled path
  task automatic m_set(input int k, input int v);
    if (m_al[k] != v) begin
      x_em[k] += em_en[k];
      x_sl[k] += sl_en[k];
      x_sn[k] += sn_en[k];
    end
    m_al[k] = v;
  endtask : m_set
  // Compare every channel with the model
  task automatic cmp_all();
    repeat (5) @(posedge clk);
    #1;
    for (int k = 0; k < 3; k++) begin
      chk(al[k], m_al[k]);
      chk(la[k], m_la[k]);
      chk(st[k], m_ln[k] ^ inv[k]);
      chk(n_em[k], x_em[k]);
      chk(n_sl[k], x_sl[k]);
      chk(n_sn[k], x_sn[k]);
    end
  endtask : cmp_all
  // New line levels through the partner; model edges, latch and alarm
  task automatic lines(input logic [2:0] v);
    int r;
    @(posedge clk);
    want <= v;
    for (int k = 0; k < 3; k++) begin
      r = (v[k] && m_ln[k] == 0) ? 1 : (!v[k] && m_ln[k] == 1) ? 2 : 0;
      // Disabled channel sees no edge at all
      if (in_en[k] && r != 0) begin
        if (trig[2*k+:2] != 2'h0 && (trig[2*k+:2] == 2'h2) == (r == 1)) m_set(k, 1);
        else if (trig[2*k+:2] != 2'h0 && m_mn[k] == 0) m_set(k, 0);
        if (r == lmode[2*k+:2]) m_la[k] = 1;
        m_ln[k] = v[k];
      end
    end
    cmp_all();
  endtask : lines
  // Bounded wait for failsafe expiry, cycles counted in n
  task automatic wait_fs();
    n = 0;
    while (fs_exp !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      err_count++;
      close_out();
    end
  endtask : wait_fs
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {rstn, io_mode, in_en, inv, lclr, sauto, sman, aclr, em_en, sl_en, sn_en} = '0;
    {want, lmode, trig, out_en, out_wr, out_val, fs_act, fs_int} = '0;
    {err_count, num_checks} = '0;
    lfsr = 32'h8FCA16B5;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk(al, 3'h0);
    chk(la, 3'h0);
    chk(man, 3'h0);
    chk({dtr_oe, rts_oe}, 2'h0);
    @(posedge clk);
    io_mode <= 1'b1;
    in_en <= 3'h7;
    inv <= 3'h2;
    trig <= 6'h06;
    lmode <= 6'h09;
    em_en <= 3'h3;
    sl_en <= 3'h1;
    sn_en <= 3'h6;
    cmp_all();
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt_rand(lfsr);
      lines(lfsr[2:0]);
    end
    @(posedge clk);
    lclr <= 3'h7;
    @(posedge clk);
    lclr <= 3'h0;
    m_la = '{0, 0, 0};
    cmp_all();
    lines(3'h0);
    @(posedge clk);
    sman <= 3'h1;
    @(posedge clk);
    sman <= 3'h0;
    m_mn[0] = 1;
    lines(3'h1);
    lines(3'h0);
    chk(man, 3'h1);
    @(posedge clk);
    aclr <= 3'h1;
    @(posedge clk);
    aclr <= 3'h0;
    m_set(0, 0);
    cmp_all();
    @(posedge clk);
    sauto <= 3'h1;
    sman <= 3'h1;
    @(posedge clk);
    {sauto, sman} <= '0;
    m_mn[0] = 0;
    cmp_all();
    chk(man, 3'h0);
    @(posedge clk);
    in_en <= 3'h6;
    lines(3'h1);
    @(posedge clk);
    in_en <= 3'h7;
    lines(3'h1);
    // Failsafe: DTR activate, RTS deactivate
    @(posedge clk);
    out_en <= 2'h3;
    fs_act <= 4'h9;
    fs_int <= 32'h0000000A;
    out_wr <= 2'h3;
    out_val <= 2'h2;
    @(posedge clk);
    out_wr <= 2'h0;
    wait_fs();
    chk(n >= 9 && n <= 13, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk(seen, 2'h1);
    lfsr = nxt_rand(lfsr);
    @(posedge clk);
    out_wr <= 2'h3;
    out_val <= lfsr[1:0];
    fs_act <= 4'h0;
    @(posedge clk);
    out_wr <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(fs_exp, 1'b0);
    chk(seen, lfsr[1:0]);
    wait_fs();
    repeat (2) @(posedge clk);
    #1;
    chk(seen, lfsr[1:0]);
    @(posedge clk);
    io_mode <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({dtr_oe, rts_oe}, 2'h0);
    close_out();
  end
endmodule : tb_ctl_line_io
`default_nettype wire
